//--- design/lbp_pkg.sv
`default_nettype none
package lbp_pkg;
	// register offsets on the byte-wide register port
	localparam logic [7:0] LBP_DRIVE_CONFIG_OFS  = 8'h42;
	localparam logic [7:0] LBP_BLINK_TIMING_OFS  = 8'h45;
	// reset values
	localparam logic [7:0] LBP_DRIVE_CONFIG_RST  = 8'h04;
	localparam logic [7:0] LBP_BLINK_TIMING_RST  = 8'h0f;
	// field positions in the drive config register
	localparam int         LBP_RANGE_LSB         = 6;
	localparam int         LBP_INVERT_BIT        = 5;
	localparam int         LBP_BRIGHT_LSB        = 0;
	// field positions in the blink timing register
	localparam int         LBP_PERIOD_LSB        = 4;
	localparam int         LBP_DUTY_LSB          = 0;
	// range select codes
	localparam logic [1:0] LBP_RANGE_OFF         = 2'h0;
	localparam logic [1:0] LBP_RANGE_3P2MA       = 2'h1;
	localparam logic [1:0] LBP_RANGE_6P4MA       = 2'h2;
	localparam logic [1:0] LBP_RANGE_12P8MA      = 2'h3;
	// timing
	localparam int         LBP_CORE_CLK_HZ       = 250_000_000;
	localparam int         LBP_ROOT_HZ           = 64;
	localparam int         LBP_ROOT_DUTY_PCT     = 10;
	localparam int         LBP_ROOT_PERIOD_CYC   = LBP_CORE_CLK_HZ / LBP_ROOT_HZ;
	localparam int         LBP_ROOT_HIGH_CYC     = LBP_ROOT_PERIOD_CYC * LBP_ROOT_DUTY_PCT / 100;
	localparam int         LBP_PERIOD_STEP_MS    = 500;
	localparam int         LBP_TICKS_PER_STEP    = LBP_ROOT_HZ * LBP_PERIOD_STEP_MS / 1000;
	localparam int         LBP_DUTY_STEPS        = 16;
	localparam int         LBP_DUTY_TICK_MUL     = LBP_TICKS_PER_STEP / LBP_DUTY_STEPS;
endpackage
`default_nettype wire

//--- design/lbp_root_clock.sv
`timescale 1ns/1ps
`default_nettype none
module lbp_root_clock
	import lbp_pkg::*;
#(
	parameter int PERIOD_CYC = LBP_ROOT_PERIOD_CYC,
	parameter int HIGH_CYC   = LBP_ROOT_HIGH_CYC
)(
	// clock and reset
	input  wire logic i_core_clk,
	input  wire logic i_rstn,
	// root clock
	output logic      o_tick,
	output logic      o_root
);
	localparam int W = $clog2(PERIOD_CYC);

	typedef struct packed
	{
		logic [W-1:0] cnt;
		logic         tick;
		logic         root;
	} lbp_root_s;

	lbp_root_s q;
	lbp_root_s d;

	// refuse a root clock the counter cannot build
	if (PERIOD_CYC < 2 || HIGH_CYC < 1 || HIGH_CYC >= PERIOD_CYC)
	begin : g_bad
		$error("lbp_root_clock: bad period or high time");
	end

	// free running divider, one tick per root period, high at the period start
	always_comb
	begin
		d = q;
		if (q.cnt == W'(PERIOD_CYC - 1))
			d.cnt = '0;
		else
			d.cnt = q.cnt + W'(1);
		d.tick = (q.cnt == W'(PERIOD_CYC - 1));
		d.root = (d.cnt < W'(HIGH_CYC));
	end

	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			q <= '0;
		else
			q <= d;
	end

	assign o_tick = q.tick;
	assign o_root = q.root;
endmodule
`default_nettype wire

//--- design/lbp_led2_channel.sv
// Operation
// R1 - range codes 01, 10, 11 enable the sink at 3.2, 6.4, 12.8 mA full scale
// R2 - range code 00 keeps the sink off whatever the other fields hold
// R3 - sink runs only with master enable set and on/off controller on
// R4 - non-inverted: each period starts on for the duty fraction, then off
// R5 - inverted: each period starts off for the duty fraction, then on
// R6 - five-bit brightness code, scaled by the range, top code is full scale
// R7 - period is half a second times period code plus one
// R8 - on fraction is one sixteenth times duty code plus one
// R9 - blink timing paced by the 64 Hz root clock, readable as status
`timescale 1ns/1ps
`default_nettype none
module lbp_led2_channel
	import lbp_pkg::*;
#(
	parameter int ROOT_PERIOD_CYC = LBP_ROOT_PERIOD_CYC,
	parameter int ROOT_HIGH_CYC   = LBP_ROOT_HIGH_CYC
)(
	// clock and reset
	input  wire logic       i_core_clk,
	input  wire logic       i_rstn,
	// shared controls from outside the channel
	input  wire logic       i_system_reset_event,
	input  wire logic       i_all_sinks_master_enable,
	input  wire logic       i_onoff_on,
	// register port
	input  wire logic [7:0] i_reg_addr,
	input  wire logic [7:0] i_reg_wdata,
	input  wire logic       i_reg_wr,
	input  wire logic       i_reg_rd,
	output logic      [7:0] o_reg_rdata,
	output logic            o_reg_ack,
	// current sink controls
	output logic            o_sink_enable,
	output logic      [1:0] o_sink_range,
	output logic      [4:0] o_sink_brightness,
	output logic            o_sink_on,
	// root clock status
	output logic            o_clk_64_status
);
	////////////////////////////////////////////////////////////////////////////////
	typedef struct packed
	{
		logic [7:0] drive;
		logic [7:0] timing;
		logic [9:0] pcnt;
		logic [7:0] rdata;
		logic       ack;
		logic       en;
		logic [1:0] range;
		logic [4:0] brt;
		logic       sink_on;
		logic       root;
	} lbp_chan_s;

	lbp_chan_s q;
	lbp_chan_s d;

	logic       root_tick;
	logic       root_lvl;
	logic [1:0] range_sel;
	logic       invert;
	logic [4:0] brt_code;
	logic [3:0] period_code;
	logic [3:0] duty_code;
	logic [9:0] period_ticks;
	logic [9:0] on_ticks;
	logic       en_now;
	logic       phase_on;
	logic [9:0] pcnt_inc;

	// 64 Hz root clock
	lbp_root_clock #(
		.PERIOD_CYC (ROOT_PERIOD_CYC),
		.HIGH_CYC   (ROOT_HIGH_CYC)
	) u_root (
		.i_core_clk (i_core_clk),
		.i_rstn     (i_rstn),
		.o_tick     (root_tick),
		.o_root     (root_lvl)
	);

	// refuse pacing constants that the 10-bit period counter cannot hold
	if (LBP_TICKS_PER_STEP != LBP_DUTY_STEPS * LBP_DUTY_TICK_MUL || LBP_TICKS_PER_STEP * 16 > 1023)
	begin : g_bad_pacing
		$error("lbp_led2_channel: blink pacing does not fit the period counter");
	end

	////////////////////////////////////////////////////////////////////////////////
	// field extraction
	assign range_sel    = q.drive[LBP_RANGE_LSB +: 2];
	assign invert       = q.drive[LBP_INVERT_BIT];
	assign brt_code     = q.drive[LBP_BRIGHT_LSB +: 5];
	assign period_code  = q.timing[LBP_PERIOD_LSB +: 4];
	assign duty_code    = q.timing[LBP_DUTY_LSB +: 4];
	// period length and on length in root ticks
	assign period_ticks = 10'({6'h0, period_code} + 10'h001) * 10'(LBP_TICKS_PER_STEP); // R7
	assign on_ticks     = 10'(({6'h0, duty_code} + 10'h001) * ({6'h0, period_code} + 10'h001)
	                      * 10'(LBP_DUTY_TICK_MUL)); // R8
	// channel gate
	assign en_now       = (range_sel != LBP_RANGE_OFF) // R2
	                      && i_all_sinks_master_enable && i_onoff_on; // R3
	assign phase_on     = (q.pcnt < on_ticks);
	// next count of the period counter before the wrap
	assign pcnt_inc     = q.pcnt + 10'h001;

	////////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		d = q;
		// register port
		d.ack = i_reg_wr | i_reg_rd;
		if (i_reg_rd)
		begin
			case (i_reg_addr)
				LBP_DRIVE_CONFIG_OFS: d.rdata = q.drive;
				LBP_BLINK_TIMING_OFS: d.rdata = q.timing;
				default:              d.rdata = 8'h00;
			endcase
		end
		if (i_reg_wr && i_reg_addr == LBP_DRIVE_CONFIG_OFS)
			d.drive = i_reg_wdata;
		if (i_reg_wr && i_reg_addr == LBP_BLINK_TIMING_OFS)
			d.timing = i_reg_wdata;
		// system reset event wins over a write
		if (i_system_reset_event)
		begin
			d.drive  = LBP_DRIVE_CONFIG_RST;
			d.timing = LBP_BLINK_TIMING_RST;
		end
		// period counter, restarts whenever the channel is gated off
		if (!en_now)
			d.pcnt = '0;
		else if (root_tick) // R9
			d.pcnt = (pcnt_inc >= period_ticks) ? 10'h000 : pcnt_inc; // R7
		// sink drive
		d.en      = en_now; // R1
		d.range   = en_now ? range_sel : LBP_RANGE_OFF; // R1
		d.brt     = en_now ? brt_code : 5'h00; // R6
		d.sink_on = en_now && (invert ? !phase_on : phase_on); // R4 R5
		d.root    = root_lvl; // R9
	end

	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			q        <= '0;
			q.drive  <= LBP_DRIVE_CONFIG_RST;
			q.timing <= LBP_BLINK_TIMING_RST;
		end
		else
			q <= d;
	end

	// outputs straight from flip-flops
	assign o_reg_rdata       = q.rdata;
	assign o_reg_ack         = q.ack;
	assign o_sink_enable     = q.en;
	assign o_sink_range      = q.range;
	assign o_sink_brightness = q.brt;
	assign o_sink_on         = q.sink_on;
	assign o_clk_64_status   = q.root;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);

	chk_range_off_gate: assert property ( // R2
		range_sel == LBP_RANGE_OFF |=> !o_sink_enable && !o_sink_on && o_sink_range == 2'h0)
		else $error("sink active with range off");
	chk_master_gate: assert property ( // R3
		o_sink_enable |-> $past(i_all_sinks_master_enable) && $past(i_onoff_on))
		else $error("sink enabled without master and on state");
	chk_range_pass: assert property ( // R1
		en_now |=> o_sink_enable && o_sink_range == $past(range_sel))
		else $error("range not passed to sink");
	chk_bright_pass: assert property ( // R6
		en_now |=> o_sink_brightness == $past(brt_code))
		else $error("brightness not passed to sink");
	// gating of the sink outputs and pacing of the period counter
	chk_gate_drop: assert property ( // R3
		!en_now |=> !o_sink_enable && !o_sink_on && o_sink_range == 2'h0
		&& o_sink_brightness == 5'h00)
		else $error("sink outputs not cleared when gated off");
	chk_period_bound: assert property ( // R7
		en_now && root_tick |=> q.pcnt < $past(period_ticks))
		else $error("period counter past period");
	chk_period_wrap: assert property ( // R7
		en_now && root_tick && pcnt_inc >= period_ticks |=> q.pcnt == 10'h000)
		else $error("period counter does not wrap at period end");
	chk_tick_pacing: assert property ( // R9
		en_now && !root_tick |=> $stable(q.pcnt))
		else $error("period counter moved without a root tick");

	// blink shape and root status
	chk_invert_edge: assert property ( // R5
		en_now && invert && q.pcnt == on_ticks |=> o_sink_on)
		else $error("inverted sink not on after duty fraction");
	chk_inphase_start: assert property ( // R4
		en_now && !invert && q.pcnt == 10'h000 |=> o_sink_on)
		else $error("in-phase period does not start on");
	chk_invert_start: assert property ( // R5
		en_now && invert && q.pcnt == 10'h000 |=> !o_sink_on)
		else $error("inverted period does not start off");
	chk_duty_edge: assert property ( // R8
		en_now && !invert && q.pcnt == on_ticks |=> !o_sink_on)
		else $error("sink still on after duty fraction");
	chk_root_status: assert property ( // R9
		o_clk_64_status == $past(root_lvl))
		else $error("root status does not follow root clock");

	cov_sink_on:     cover property (o_sink_enable && o_sink_on);
	cov_invert_on:   cover property (o_sink_enable && invert && o_sink_on);
	cov_period_wrap: cover property (en_now && root_tick && q.pcnt + 10'h001 == period_ticks);
	cov_system_reset_event:      cover property (i_system_reset_event && i_reg_wr);
	cov_invert_edge: cover property (en_now && invert && q.pcnt == on_ticks);
endmodule
`default_nettype wire

//--- dv/lbp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module lbp_host_model
	import lbp_pkg::*;
(
	// clock
	input  wire logic       i_core_clk,
	// register port
	output logic      [7:0] o_reg_addr,
	output logic      [7:0] o_reg_wdata,
	output logic            o_reg_wr,
	output logic            o_reg_rd,
	input  wire logic [7:0] i_reg_rdata,
	input  wire logic       i_reg_ack
);
	// idle port at time zero
	initial
	begin
		o_reg_addr = 8'h00;
		o_reg_wdata = 8'h00;
		o_reg_wr = 1'b0;
		o_reg_rd = 1'b0;
	end
	// one byte access: one-cycle strobe, address held until the ack edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] dt,
		output logic [7:0] r, output logic ok);
		int n;
		o_reg_addr <= a;
		o_reg_wdata <= dt;
		o_reg_wr <= w;
		o_reg_rd <= !w;
		@(posedge i_core_clk);
		o_reg_wr <= 1'b0;
		o_reg_rd <= 1'b0;
		n = 0;
		do
		begin
			@(posedge i_core_clk);
			n++;
		end
		while (i_reg_ack !== 1'b1 && n < 4);
		ok = (i_reg_ack === 1'b1);
		r = i_reg_rdata;
		// released lines must not keep the last value
		o_reg_addr <= ~a;
		o_reg_wdata <= ~dt;
		// one idle edge, so a following call never rewrites these in this time step
		@(posedge i_core_clk);
	endtask
endmodule
`default_nettype wire

//--- dv/lbp_led2_channel_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lbp_led2_channel_tb
	import lbp_pkg::*;
;
	localparam int RP = 20;
	localparam int RH = 2;
	logic        core_clk, rstn, sys_rst, mst_en, onoff, wr, rd, ack;
	logic        sink_en, sink_on, clk64, iv, ph, en;
	logic [7:0]  addr, wdata, rdata;
	logic [1:0]  sink_rng;
	logic [4:0]  sink_brt;
	logic [3:0]  p, d;
	logic [8:0]  cs;
	logic [8:0]  tbl [5] = '{9'h000, 9'h01f, 9'h10f, 9'h125, 9'h031};
	logic [15:0] cnt, hi, on;
	logic [31:0] rnd = 32'hd2bfbd1e;
	int          num_errors = 0;
	int          checked = 0;
	int          k, n;
	lbp_led2_channel #(.ROOT_PERIOD_CYC(RP), .ROOT_HIGH_CYC(RH)) u_lbp_led2_channel (
		.i_core_clk(core_clk), .i_rstn(rstn), .i_system_reset_event(sys_rst),
		.i_all_sinks_master_enable(mst_en), .i_onoff_on(onoff), .i_reg_addr(addr),
		.i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
		.o_reg_ack(ack), .o_sink_enable(sink_en), .o_sink_range(sink_rng),
		.o_sink_brightness(sink_brt), .o_sink_on(sink_on), .o_clk_64_status(clk64));
	lbp_host_model u_lbp_host_model (
		.i_core_clk(core_clk), .o_reg_addr(addr), .o_reg_wdata(wdata), .o_reg_wr(wr),
		.o_reg_rd(rd), .i_reg_rdata(rdata), .i_reg_ack(ack));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// expected sink-on cycles over one whole blink period
	function automatic logic [15:0] exp_on(input logic v, input logic [3:0] pc,
		input logic [3:0] dc);
		logic [15:0] all;
		logic [15:0] lit;
		all = 16'((pc + 1) * LBP_TICKS_PER_STEP * RP);
		lit = 16'((dc + 1) * (pc + 1) * LBP_DUTY_TICK_MUL * RP);
		return v ? all - lit : lit;
	endfunction
	task automatic stop_test;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// register access with ack check and, for reads, data check
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] dt,
		input logic [7:0] ex);
		logic [7:0] r;
		logic ok;
		u_lbp_host_model.xfer(w, a, dt, r, ok);
		chk({15'h0, ok}, 16'h1);
		if (!ok)
			stop_test();
		else if (!w)
			chk({8'h0, r}, {8'h0, ex});
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// clock and hang guard
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	initial
	begin
		#400000;
		num_errors++;
		stop_test();
	end
	// main sequence
	initial
	begin
		{rstn, sys_rst, mst_en, onoff} = 4'h0;
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		acc(1'b0, LBP_DRIVE_CONFIG_OFS, 8'h00, LBP_DRIVE_CONFIG_RST);
		acc(1'b0, LBP_BLINK_TIMING_OFS, 8'h00, LBP_BLINK_TIMING_RST);
		acc(1'b0, 8'h43, 8'h00, 8'h00);
		for (k = 0; k < 8; k++)
		begin
			rnd = nxt(rnd);
			acc(1'b1, k[0] ? LBP_BLINK_TIMING_OFS : LBP_DRIVE_CONFIG_OFS, rnd[7:0], 8'h00);
			acc(1'b0, k[0] ? LBP_BLINK_TIMING_OFS : LBP_DRIVE_CONFIG_OFS, 8'h00, rnd[7:0]);
		end
		// system reset event restores both registers and wins over a write
		sys_rst <= 1'b1;
		acc(1'b1, LBP_DRIVE_CONFIG_OFS, 8'hff, 8'h00);
		sys_rst <= 1'b0;
		// writes to unmapped offsets land nowhere
		acc(1'b1, 8'h43, 8'hff, 8'h00);
		acc(1'b1, 8'h44, 8'hff, 8'h00);
		acc(1'b0, LBP_DRIVE_CONFIG_OFS, 8'h00, LBP_DRIVE_CONFIG_RST);
		acc(1'b0, LBP_BLINK_TIMING_OFS, 8'h00, LBP_BLINK_TIMING_RST);
		// every range code against every gate combination
		for (k = 0; k < 16; k++)
		begin
			rnd = nxt(rnd);
			acc(1'b1, LBP_DRIVE_CONFIG_OFS, {k[1:0], 1'b0, rnd[4:0]}, 8'h00);
			mst_en <= k[2];
			onoff <= k[3];
			repeat (3) @(posedge core_clk);
			en = k[1:0] != 2'h0 && k[2] && k[3];
			chk({8'h0, sink_en, sink_rng, sink_brt}, en ? {8'h0, 1'b1, k[1:0], rnd[4:0]} : 16'h0);
			if (!en)
				chk({15'h0, sink_on}, 16'h0);
		end
		// blink shape over one whole period per case
		for (k = 0; k < 6; k++)
		begin
			rnd = nxt(rnd);
			cs = (k < 5) ? tbl[k] : {rnd[8], 2'b00, rnd[5:0]};
			{iv, p, d} = cs;
			mst_en <= 1'b0;
			acc(1'b1, LBP_BLINK_TIMING_OFS, {p, d}, 8'h00);
			acc(1'b1, LBP_DRIVE_CONFIG_OFS, {2'h3, iv, 5'h1f}, 8'h00);
			mst_en <= 1'b1;
			onoff <= 1'b1;
			n = 0;
			while (sink_en !== 1'b1 && n < 8)
			begin
				@(posedge core_clk);
				n++;
			end
			if (n == 8)
			begin
				num_errors++;
				stop_test();
			end
			@(posedge core_clk);
			ph = sink_on;
			{cnt, hi} = 32'h0;
			repeat ((p + 1) * 32 * RP)
			begin
				@(posedge core_clk);
				cnt += {15'h0, sink_on};
				hi += {15'h0, clk64};
			end
			on = exp_on(iv, p, d);
			chk({15'h0, ph}, {15'h0, !iv});
			chk(cnt, on);
			chk(hi, 16'((p + 1) * 32 * RH));
		end
		stop_test();
	end
endmodule
`default_nettype wire
